// *** common/dma_pkg.sv ***
// shared constants for the four-channel dma controller
// Notes on behaviour
// - byte instance decodes I/O 0..Fh; word instance decodes C0h..DFh.
// - word instance selects registers from A1..A4; only even addresses respond.
// - all accesses are bytes; 16-bit registers go low byte then high byte.
// - any write to the byte-select clear port points the toggle at the low byte.
// - command register is write-only; reading its address returns status.
// - command zero: fixed priority, request active high, acknowledge active low.
// - mode write updates only the channel named by data bits 1:0.
// - mode bits 3:2 give direction; bit 5 picks address increment or decrement.
// - mode bits 7:6: 00 demand, 01 single, 10 block, 11 cascade.
// - without auto-initialise, terminal count sets the channel mask bit.
// - with auto-initialise, terminal count reloads address and count from base.
// - single mode: one transfer per request, then the bus is released.
// - block mode: one request runs transfers until terminal count, or endlessly with auto-initialise; request ignored.
// - demand mode: pause while request is low, resume where it stopped.
// - cascade mode: request and acknowledge act as hold request and acknowledge.
// - each channel has a write-only mask; the all-mask port loads every bit.
// - single-mask port sets or clears one channel's mask, others untouched.
// - one 16-bit address register per channel at index twice the channel.
// - reading an address register returns the current address.
// - count loaded as N-1, decrements; rolling 0 to FFFFh drives terminal count.
// - status read reports per channel request activity and finished transfer.
// - a request arriving while masked is held and granted once unmasked.
package dma_pkg;
  localparam logic [3:0] OFS_CMD_STAT = 4'h8;
  localparam logic [3:0] OFS_MASK_ONE = 4'hA;
  localparam logic [3:0] OFS_MODE = 4'hB;
  localparam logic [3:0] OFS_PTR_CLR = 4'hC;
  localparam logic [3:0] OFS_MASK_ALL = 4'hF;
  localparam logic [11:0] BYTE_PAGE = 12'h000;
  localparam logic [10:0] WORD_PAGE = 11'h006;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h40;
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam int CMD_DIS_BIT = 2;
  localparam int CMD_REQ_LOW_BIT = 6;
  localparam int CMD_ACK_HIGH_BIT = 7;
  localparam int MODE_AUTO_BIT = 4;
  localparam int MODE_DEC_BIT = 5;
  localparam int MASK_SET_BIT = 2;
  localparam logic [15:0] CNT_ROLL = 16'hFFFF;
  localparam logic [1:0] XT_DEMAND = 2'h0;
  localparam logic [1:0] XT_SINGLE = 2'h1;
  localparam logic [1:0] XT_BLOCK = 2'h2;
  localparam logic [1:0] XT_CASCADE = 2'h3;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_CASC = 3'b100
  } eng_state_t;
endpackage

// *** design/four_channel_dma_controller.sv ***
// four-channel dma controller with byte-wide register port and transfer fifo
`timescale 1ns/1ps

module dma_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != CW'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

module four_channel_dma_controller #(
  parameter bit WORD_INST = 1'b0,
  parameter int DATA_W = 16,
  parameter int FIFO_D = dma_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  input wire logic [3:0] dreq,
  output logic [3:0] dack_n,
  output logic tc_out,
  input wire logic [DATA_W-1:0] per_data,
  output logic mem_valid,
  output logic [16:0] mem_addr,
  output logic [1:0] mem_dir,
  output logic [DATA_W-1:0] mem_data,
  input wire logic mem_ready
);
  localparam int FW = 2 + 17 + DATA_W;

  function automatic logic [2:0] lowest_set(input logic [3:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] step_addr(input logic [15:0] a, input logic dec);
    return dec ? a - 16'h0001 : a + 16'h0001;
  endfunction

  // register decode
  logic hit;
  logic [3:0] idx;
  always_comb begin
    if (WORD_INST) begin
      hit = (io_addr[15:5] == dma_pkg::WORD_PAGE) && !io_addr[0];
      idx = io_addr[4:1];
    end else begin
      hit = (io_addr[15:4] == dma_pkg::BYTE_PAGE);
      idx = io_addr[3:0];
    end
  end

  logic wr_hit;
  logic rd_hit;
  logic wide;
  logic [1:0] reg_ch;
  assign wr_hit = ce & io_wr & hit;
  assign rd_hit = ce & io_rd & hit;
  assign wide = ~idx[3];
  assign reg_ch = idx[2:1];

  logic [7:0] cmd_r;
  logic [7:0] mode_r [4];
  logic [3:0] mask_r;
  logic toggle_r;
  logic [15:0] base_addr_r [4];
  logic [15:0] cur_addr_r [4];
  logic [15:0] base_cnt_r [4];
  logic [15:0] cur_cnt_r [4];
  logic [3:0] tc_flag_r;
  logic [3:0] req_lat_r;

  // request pin synchroniser
  logic [3:0] rq_s1_r;
  logic [3:0] rq_s2_r;
  logic [3:0] rq_s3_r;
  logic [3:0] rq_lvl_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rq_s1_r <= '0;
      rq_s2_r <= '0;
      rq_s3_r <= '0;
      rq_lvl_r <= '0;
    end else if (ce) begin
      rq_s1_r <= dreq;
      rq_s2_r <= rq_s1_r;
      rq_s3_r <= rq_s2_r;
      for (int i = 0; i < 4; i++) begin
        if (rq_s2_r[i] == rq_s3_r[i]) begin
          rq_lvl_r[i] <= rq_s3_r[i];
        end
      end
    end
  end

  logic [3:0] req_act;
  logic [3:0] pend;
  logic [2:0] pick;
  assign req_act = rq_lvl_r ^ {4{cmd_r[dma_pkg::CMD_REQ_LOW_BIT]}};
  assign pend = (req_act | req_lat_r) & ~mask_r
                & {4{~cmd_r[dma_pkg::CMD_DIS_BIT]}};
  assign pick = lowest_set(pend);

  // engine
  dma_pkg::eng_state_t state_r;
  logic [1:0] act_ch_r;
  logic fifo_in_ready;
  logic [7:0] act_mode;
  logic [1:0] act_type;
  logic act_auto;
  logic push;
  logic is_tc;
  logic tc_evt;
  logic grant;
  assign act_mode = mode_r[act_ch_r];
  assign act_type = act_mode[7:6];
  assign act_auto = act_mode[dma_pkg::MODE_AUTO_BIT];
  // demand mode only moves data while the request stays up
  assign push = ce && (state_r == dma_pkg::ST_XFER) && fifo_in_ready
                && (act_type != dma_pkg::XT_DEMAND || req_act[act_ch_r]);
  assign is_tc = (cur_cnt_r[act_ch_r] == 16'h0000);
  assign tc_evt = push && is_tc;
  assign grant = ce && (state_r == dma_pkg::ST_IDLE) && pick[2];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= dma_pkg::ST_IDLE;
      act_ch_r <= 2'h0;
    end else if (ce) begin
      case (state_r)
        dma_pkg::ST_IDLE: begin
          if (pick[2]) begin
            act_ch_r <= pick[1:0];
            if (mode_r[pick[1:0]][7:6] == dma_pkg::XT_CASCADE) begin
              state_r <= dma_pkg::ST_CASC;
            end else begin
              state_r <= dma_pkg::ST_XFER;
            end
          end
        end
        dma_pkg::ST_XFER: begin
          if (act_type == dma_pkg::XT_DEMAND && !req_act[act_ch_r]) begin
            state_r <= dma_pkg::ST_IDLE;
          end else if (push) begin
            if (act_type == dma_pkg::XT_SINGLE) begin
              state_r <= dma_pkg::ST_IDLE;
            end else if (is_tc && !act_auto) begin
              state_r <= dma_pkg::ST_IDLE;
            end
          end
        end
        dma_pkg::ST_CASC: begin
          if (!req_act[act_ch_r]) begin
            state_r <= dma_pkg::ST_IDLE;
          end
        end
        default: state_r <= dma_pkg::ST_IDLE;
      endcase
    end
  end

  // acknowledge and terminal count pins
  logic [3:0] ack_on;
  always_comb begin
    ack_on = 4'h0;
    if (state_r != dma_pkg::ST_IDLE) begin
      ack_on[act_ch_r] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dack_n <= 4'hF;
      tc_out <= 1'b0;
    end else if (ce) begin
      dack_n <= ~ack_on ^ {4{cmd_r[dma_pkg::CMD_ACK_HIGH_BIT]}};
      tc_out <= tc_evt;
    end
  end

  // command, mode and mask registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_r <= dma_pkg::CMD_RST;
      for (int i = 0; i < 4; i++) begin
        mode_r[i] <= dma_pkg::MODE_RST;
      end
    end else if (wr_hit) begin
      if (idx == dma_pkg::OFS_CMD_STAT) begin
        cmd_r <= io_wdata;
      end
      if (idx == dma_pkg::OFS_MODE) begin
        mode_r[io_wdata[1:0]] <= io_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_r <= dma_pkg::MASK_RST;
    end else if (ce) begin
      if (tc_evt && !act_auto) begin
        mask_r[act_ch_r] <= 1'b1;
      end else if (wr_hit && idx == dma_pkg::OFS_MASK_ALL) begin
        mask_r <= io_wdata[3:0];
      end else if (wr_hit && idx == dma_pkg::OFS_MASK_ONE) begin
        mask_r[io_wdata[1:0]] <= io_wdata[dma_pkg::MASK_SET_BIT];
      end
    end
  end

  // a request seen while masked is held until its channel is granted
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_lat_r <= 4'h0;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        req_lat_r[i] <= (req_lat_r[i] && !(grant && pick[1:0] == 2'(i)))
                        || (req_act[i] && mask_r[i]);
      end
    end
  end

  // byte toggle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      toggle_r <= 1'b0;
    end else if (wr_hit && idx == dma_pkg::OFS_PTR_CLR) begin
      toggle_r <= 1'b0;
    end else if ((wr_hit || rd_hit) && wide) begin
      toggle_r <= ~toggle_r;
    end
  end

  // address and count registers; host writes win over the engine, since
  // software masks a channel before reprogramming it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        base_addr_r[i] <= 16'h0000;
        cur_addr_r[i] <= 16'h0000;
        base_cnt_r[i] <= 16'h0000;
        cur_cnt_r[i] <= 16'h0000;
      end
    end else if (wr_hit && wide) begin
      if (!idx[0]) begin
        if (toggle_r) begin
          base_addr_r[reg_ch][15:8] <= io_wdata;
          cur_addr_r[reg_ch][15:8] <= io_wdata;
        end else begin
          base_addr_r[reg_ch][7:0] <= io_wdata;
          cur_addr_r[reg_ch][7:0] <= io_wdata;
        end
      end else if (toggle_r) begin
        base_cnt_r[reg_ch][15:8] <= io_wdata;
        cur_cnt_r[reg_ch][15:8] <= io_wdata;
      end else begin
        base_cnt_r[reg_ch][7:0] <= io_wdata;
        cur_cnt_r[reg_ch][7:0] <= io_wdata;
      end
    end else if (push) begin
      if (is_tc && act_auto) begin
        cur_addr_r[act_ch_r] <= base_addr_r[act_ch_r];
        cur_cnt_r[act_ch_r] <= base_cnt_r[act_ch_r];
      end else begin
        cur_addr_r[act_ch_r] <= step_addr(cur_addr_r[act_ch_r],
                                          act_mode[dma_pkg::MODE_DEC_BIT]);
        cur_cnt_r[act_ch_r] <= cur_cnt_r[act_ch_r] - 16'h0001;
      end
    end
  end

  // finished flags clear on a status read; a count arriving then still sets
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tc_flag_r <= 4'h0;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        if (tc_evt && act_ch_r == 2'(i)) begin
          tc_flag_r[i] <= 1'b1;
        end else if (rd_hit && idx == dma_pkg::OFS_CMD_STAT) begin
          tc_flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // read port
  logic [15:0] rd_word;
  assign rd_word = idx[0] ? cur_cnt_r[reg_ch] : cur_addr_r[reg_ch];
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
    end else if (ce && io_rd) begin
      if (!hit) begin
        io_rdata <= 8'h00;
      end else if (wide) begin
        io_rdata <= toggle_r ? rd_word[15:8] : rd_word[7:0];
      end else if (idx == dma_pkg::OFS_CMD_STAT) begin
        io_rdata <= {req_act | req_lat_r, tc_flag_r};
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

  // transfer data path
  logic [16:0] out_addr;
  logic [FW-1:0] fifo_in;
  logic [FW-1:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_out_ready;
  assign out_addr = WORD_INST ? {cur_addr_r[act_ch_r], 1'b0} : {1'b0, cur_addr_r[act_ch_r]};
  assign fifo_in = {act_mode[3:2], out_addr, per_data};
  // the output register only takes a word when it is empty or being drained
  assign fifo_out_ready = !mem_valid || mem_ready;

  dma_fifo #(
    .W(FW),
    .D(FIFO_D)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mem_valid <= 1'b0;
      mem_dir <= 2'h0;
      mem_addr <= 17'h00000;
      mem_data <= '0;
    end else if (ce && fifo_out_ready) begin
      mem_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        mem_dir <= fifo_out[FW-1:FW-2];
        mem_addr <= fifo_out[FW-3:DATA_W];
        mem_data <= fifo_out[DATA_W-1:0];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_tc_sets_mask: assert property (tc_evt && !act_auto |=> mask_r[$past(act_ch_r)])
    else $error("terminal count did not mask the channel");
  a_tc_reloads: assert property (tc_evt && act_auto |=>
    cur_cnt_r[$past(act_ch_r)] == base_cnt_r[$past(act_ch_r)])
    else $error("auto-initialise did not reload the count");
  a_tc_pin_cause: assert property (tc_out |-> $past(tc_evt))
    else $error("terminal count pin without a rollover");
  a_ptr_clear: assert property (wr_hit && idx == dma_pkg::OFS_PTR_CLR |=> !toggle_r)
    else $error("byte toggle not cleared");
  a_ptr_flip: assert property ((wr_hit || rd_hit) && wide |=> toggle_r != $past(toggle_r))
    else $error("byte toggle did not flip");
  a_single_release: assert property (push && act_type == dma_pkg::XT_SINGLE
    |=> state_r == dma_pkg::ST_IDLE
    ##1 dack_n[$past(act_ch_r, 2)] == ~cmd_r[dma_pkg::CMD_ACK_HIGH_BIT])
    else $error("single transfer kept the bus");
  a_grant_unmasked: assert property (grant |-> !mask_r[pick[1:0]])
    else $error("masked channel granted");
  a_fixed_prio: assert property (grant |-> ((pend & ((4'h1 << pick[1:0]) - 4'h1)) == 4'h0))
    else $error("lower channel was pending");
  a_demand_pause: assert property (state_r == dma_pkg::ST_XFER && act_type == dma_pkg::XT_DEMAND
    && !req_act[act_ch_r] |-> !push ##1 state_r == dma_pkg::ST_IDLE)
    else $error("demand transfer ran without request");
  c_block_run: cover property (push && act_type == dma_pkg::XT_BLOCK ##1 push ##1 push);
  c_auto_wrap: cover property (tc_evt && act_auto);
  c_cascade: cover property (state_r == dma_pkg::ST_CASC);
  c_fifo_full: cover property (state_r == dma_pkg::ST_XFER && !fifo_in_ready);
endmodule

// *** tb/periph_mem_model.sv ***
// far side model: peripheral data source and memory sink that can stall
`timescale 1ns/1ps
module periph_mem_model (
  input wire logic clk_sys,
  input wire logic stall,
  input wire logic slow,
  input wire logic [15:0] word,
  output logic [15:0] per_data,
  output logic mem_ready
);
  assign per_data = word;
  initial mem_ready = 1'b0;
  // slow accepts every other cycle so mem_valid must hold across refusals
  always @(posedge clk_sys) begin
    mem_ready <= !stall && (!slow || !mem_ready);
  end
endmodule

// *** tb/tb_four_channel_dma_controller.sv ***
// self-checking bench for the four-channel dma controller
`timescale 1ns/1ps
module tb_four_channel_dma_controller;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic ce = 1'b1;
  logic [3:0] dreq = 4'h0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [7:0] rd_b, rd_w, r8;
  logic [3:0] dack_n;
  logic tc_out, mem_valid, mem_ready;
  logic [16:0] mem_addr;
  logic [1:0] mem_dir;
  logic [15:0] per_data, mem_data, r16, b0, b1;
  logic [33:0] q[$];
  int error_cnt = 0;
  int compares = 0;
  int tcs = 0;
  int n1;

  four_channel_dma_controller i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(rd_b),
    .dreq(dreq), .dack_n(dack_n), .tc_out(tc_out), .per_data(per_data),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_dir(mem_dir), .mem_data(mem_data),
    .mem_ready(mem_ready));
  // word instance shares the i/o bus; its channels stay masked
  four_channel_dma_controller #(.WORD_INST(1'b1)) i_word (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .ce(ce), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata(rd_w), .dreq(dreq), .dack_n(), .tc_out(), .per_data(per_data),
    .mem_valid(), .mem_addr(), .mem_dir(), .mem_data(), .mem_ready(mem_ready));
  periph_mem_model i_far (.clk_sys(clk_sys), .stall(stall), .slow(slow), .word(word),
    .per_data(per_data), .mem_ready(mem_ready));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (mem_valid && mem_ready) q.push_back({mem_dir, mem_addr[15:0], mem_data});
    if (tc_out) tcs++;
  end

  task automatic test_done();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk_val(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    @(posedge clk_sys);
    #1 d = (a >= 16'h00C0) ? rd_w : rd_b;
  endtask

  task automatic wr16(input logic [15:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask

  task automatic rd16(input logic [15:0] a, output logic [15:0] v);
    logic [7:0] lo, hi;
    rd(a, lo);
    rd(a, hi);
    v = {hi, lo};
  endtask

  // count is loaded as transfers minus one
  task automatic prog(input int c, input logic [7:0] m, input logic [15:0] b,
                      input logic [15:0] n);
    wr(16'h000A, 8'h04 | 8'(c));
    wr(16'h000B, m | 8'(c));
    wr(16'h000C, 8'h00);
    wr16(16'(2 * c), b);
    wr16(16'(2 * c + 1), n);
  endtask

  task automatic wait_ack(input int c, input logic v);
    int k;
    k = 0;
    while (dack_n[c] !== v && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  task automatic wait_tc(input int n);
    int k;
    k = 0;
    while (tcs < n && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (q.size() < n && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  function automatic logic [33:0] ex(logic [1:0] d, logic [15:0] b, int i, bit dec);
    return {d, dec ? b - 16'(i) : b + 16'(i), word};
  endfunction

  task automatic xfers(input int n, input logic [1:0] d, input logic [15:0] b,
                       input bit dec, input int len);
    wait_q(n);
    for (int i = 0; i < n; i++) chk_val(q.size() > 0 ? q.pop_front() : 'x, ex(d, b, i % len, dec));
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end

  initial begin
    r16 = 16'($urandom(64));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk_val({dack_n, tc_out, mem_valid}, 6'h3C);
    rd(16'h0008, r8);
    chk_val(r8, 8'h00);
    rd(16'h000B, r8);
    chk_val(r8, 8'h00);
    $display("done: reset");
    for (int c = 0; c < 8; c++) begin
      r16 = 16'($urandom);
      wr(16'h000C, 8'h00);
      wr16(16'(c), r16);
      wr(16'h000C, 8'h00);
      rd16(16'(c), b0);
      chk_val(b0, r16);
    end
    wr(16'h000C, 8'h00);
    wr(16'h0000, 8'h11);
    wr(16'h000C, 8'h00);
    wr16(16'h0000, 16'h3322);
    wr(16'h000C, 8'h00);
    rd(16'h0000, r8);
    rd16(16'h0000, r16);
    chk_val(r16, 16'h2233);
    // with the clock enable low, register writes must leave no trace
    ce <= 1'b0;
    wr(16'h000C, 8'h00);
    wr16(16'h0000, 16'h5A5A);
    ce <= 1'b1;
    wr(16'h000C, 8'h00);
    rd16(16'h0000, r16);
    chk_val(r16, 16'h3322);
    r16 = 16'($urandom);
    wr(16'h00D8, 8'h00);
    wr16(16'h00C4, r16);
    wr(16'h00D8, 8'h00);
    rd16(16'h00C4, b0);
    chk_val(b0, r16);
    rd(16'h00C5, r8);
    chk_val(r8, 8'h00);
    rd(16'h0010, r8);
    chk_val(r8, 8'h00);
    $display("done: registers");
    wr(16'h0008, 8'h80);
    repeat (3) @(posedge clk_sys);
    chk_val(dack_n, 4'h0);
    rd(16'h0008, r8);
    chk_val(r8, 8'h00);
    wr(16'h0008, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk_val(dack_n, 4'hF);
    $display("done: command");
    b1 = 16'($urandom);
    n1 = tcs;
    prog(1, 8'h44, b1, 16'h0003);
    word <= 16'($urandom);
    wr(16'h000A, 8'h01);
    dreq[1] <= 1'b1;
    wait_tc(n1 + 1);
    // request stays up: a channel masked by terminal count must stay quiet
    repeat (30) @(posedge clk_sys);
    dreq[1] <= 1'b0;
    xfers(4, 2'h1, b1, 0, 4);
    chk_val(q.size(), 0);
    chk_val(tcs - n1, 1);
    rd(16'h0008, r8);
    chk_val(r8, 8'h22);
    rd(16'h0008, r8);
    chk_val(r8, 8'h20);
    wr(16'h000C, 8'h00);
    rd16(16'h0002, r16);
    chk_val(r16, b1 + 16'h0004);
    rd16(16'h0003, r16);
    chk_val(r16, 16'hFFFF);
    $display("done: single");
    b0 = 16'($urandom);
    prog(2, 8'h78, b0, 16'h0001);
    wr(16'h000A, 8'h02);
    dreq[2] <= 1'b1;
    wait_q(5);
    wr(16'h000A, 8'h06);
    dreq[2] <= 1'b0;
    repeat (20) @(posedge clk_sys);
    xfers(q.size(), 2'h2, b0, 1, 2);
    $display("done: auto reload");
    stall <= 1'b1;
    b1 = 16'($urandom);
    prog(3, 8'h88, b1, 16'h000B);
    wr(16'h000A, 8'h03);
    dreq[3] <= 1'b1;
    wait_ack(3, 1'b0);
    dreq[3] <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk_val(mem_valid, 1'b1);
    chk_val(q.size(), 0);
    stall <= 1'b0;
    slow <= 1'b1;
    xfers(12, 2'h2, b1, 0, 12);
    slow <= 1'b0;
    $display("done: block");
    b0 = 16'($urandom);
    prog(0, 8'h00, b0, 16'h000F);
    wr(16'h000A, 8'h00);
    dreq[0] <= 1'b1;
    wait_ack(0, 1'b0);
    repeat (2) @(posedge clk_sys);
    dreq[0] <= 1'b0;
    repeat (30) @(posedge clk_sys);
    n1 = q.size();
    repeat (20) @(posedge clk_sys);
    chk_val(q.size(), n1);
    chk_val(n1 < 16, 1'b1);
    dreq[0] <= 1'b1;
    wait_tc(tcs + 1);
    dreq[0] <= 1'b0;
    xfers(16, 2'h0, b0, 0, 16);
    $display("done: demand");
    b0 = 16'($urandom);
    b1 = 16'($urandom);
    prog(0, 8'h40, b0, 16'h0000);
    prog(1, 8'h44, b1, 16'h0000);
    dreq[1:0] <= 2'h3;
    repeat (10) @(posedge clk_sys);
    dreq[1:0] <= 2'h0;
    repeat (10) @(posedge clk_sys);
    chk_val(q.size(), 0);
    wr(16'h000F, 8'h0C);
    xfers(1, 2'h0, b0, 0, 1);
    xfers(1, 2'h1, b1, 0, 1);
    $display("done: priority");
    prog(3, 8'hC0, b0, 16'h0000);
    wr(16'h000A, 8'h03);
    dreq[3] <= 1'b1;
    wait_ack(3, 1'b0);
    repeat (10) @(posedge clk_sys);
    chk_val(dack_n[3], 1'b0);
    chk_val(q.size(), 0);
    dreq[3] <= 1'b0;
    wait_ack(3, 1'b1);
    chk_val(dack_n[3], 1'b1);
    $display("done: cascade");
    test_done();
  end
endmodule
